/* File: core/gsf_core.sv */
// Function
// [R1] torque low-pass filter always on
// [R2] auto corner: speed gain over (1+inertia), times ten
// [R3] select second digit 1 picks manual frequency
// [R4] switching only in manual tuning mode 3
// [R5] swap four active gains per code and threshold
// [R6] model loop gain never switched
// [R7] change condition uses alternate loop gains
// [R8] change condition uses alternate vibration settings
// [R9] condition decoded from code digits one, two
// [R10] first digit 1: host command triggers change
// [R11] compare frequency, droop or speed against threshold
// [R12] switched gains follow first-order lag, ms constant
// [R13] supports stopped/rotating and external switching
// [R14] manual vibration mode uses configured frequencies
// [R15] host lowers model gain if suppression ineffective
// [R16] host copies inertia when it does not change
// [R17] host sets distinct anti-resonance, resonance values
// [R18] code 0001: input state selects gain set
// [R19] code 0003: droop over threshold selects alternate
// [R20] zero time constant: step in next cycle
// [R21] updates applied only at control cycle boundary
module gsf_core (
   input wire logic clk_in,
   input wire logic rst_in,
   input wire logic [7:0] addr_in,
   input wire logic [15:0] wdata_in,
   input wire logic wr_in,
   input wire logic rd_in,
   output logic [15:0] rdata_out,
   input wire logic host_switch_cmd_in,
   input wire logic [15:0] cmd_freq_in,
   input wire logic [15:0] droop_pulses_in,
   input wire logic [15:0] motor_speed_in,
   output logic ctrl_tick_out,
   output logic gain_switched_out,
   output logic [15:0] model_loop_gain_out,
   output logic [15:0] position_loop_gain_out,
   output logic [15:0] speed_loop_gain_out,
   output logic [15:0] speed_integral_comp_out,
   output logic [15:0] inertia_ratio_out,
   output logic [15:0] lowpass_freq_out,
   output logic [15:0] vibration_freq_out,
   output logic [15:0] resonance_freq_out
);

   // ------------------------------------------------------------
   // functions
   // ------------------------------------------------------------
   function automatic logic [15:0] cfg_rst(input int idx);
      logic [15:0] v;
      v = 16'h0000;
      unique case (idx)
         0: v = gsf_pkg::RST_MODEL_LOOP_GAIN;
         1: v = gsf_pkg::RST_INERTIA_RATIO;
         2: v = gsf_pkg::RST_POSITION_LOOP_GAIN;
         3: v = gsf_pkg::RST_SPEED_LOOP_GAIN;
         4: v = gsf_pkg::RST_SPEED_INTEGRAL_COMP;
         5: v = gsf_pkg::RST_ALT_INERTIA_RATIO;
         6: v = gsf_pkg::RST_ALT_POSITION_LOOP_GAIN;
         7: v = gsf_pkg::RST_ALT_SPEED_LOOP_GAIN;
         8: v = gsf_pkg::RST_ALT_SPEED_INTEGRAL_COMP;
         9: v = gsf_pkg::RST_GAIN_SWITCH_SELECT;
         10: v = gsf_pkg::RST_GAIN_SWITCH_THRESHOLD;
         11: v = gsf_pkg::RST_GAIN_SWITCH_TIME_CONSTANT;
         12: v = gsf_pkg::RST_VIB_FREQ;
         13: v = gsf_pkg::RST_RES_FREQ;
         14: v = gsf_pkg::RST_VIB_FREQ;
         15: v = gsf_pkg::RST_RES_FREQ;
         16: v = gsf_pkg::RST_LOWPASS_SELECT;
         17: v = gsf_pkg::RST_LOWPASS_MANUAL_FREQ;
         18: v = gsf_pkg::RST_TUNING_MODE_SELECT;
         default: v = gsf_pkg::RST_VIB_SUPPRESS_MODE;
      endcase
      return v;
   endfunction

   // digit extraction shared by selection code and low-pass select
   function automatic logic [3:0] digit(input logic [15:0] v, input int lsb);
      return v[lsb +: gsf_pkg::DIGIT_W];
   endfunction

   // one control-cycle step of the lag toward target
   function automatic logic [15:0] lag_step(input logic [15:0] cur, input logic [15:0] tgt,
                                            input logic [15:0] tc);
      logic signed [17:0] diff;
      logic signed [22:0] den;
      logic signed [22:0] step;
      logic [15:0] res;
      diff = $signed({2'b00, tgt}) - $signed({2'b00, cur});
      den = $signed({7'h00, tc}) * $signed(23'(gsf_pkg::TICKS_PER_MS));
      step = 23'sh000000;
      res = cur;
      if (tc == 16'h0000) begin
         res = tgt; // R20
      end else begin
         step = 23'(diff) / den; // R12
         if (step == 23'sh000000 && diff != 18'sh00000) begin
            step = (diff > 18'sh00000) ? 23'sh000001 : -23'sh000001;
         end
         res = 16'(23'($signed({7'h00, cur})) + step);
      end
      return res;
   endfunction

   // ------------------------------------------------------------
   // parameter registers
   // ------------------------------------------------------------
   logic [15:0] cfg_ff [gsf_pkg::N_CFG];
   logic [15:0] app_ff [gsf_pkg::N_CFG];
   logic [11:0] tick_cnt_ff;
   logic ctrl_tick_ff;
   logic [11:0] nxt_tick_cnt;
   logic tick_wrap;

   genvar gi;
   generate
      for (gi = 0; gi < gsf_pkg::N_CFG; gi++) begin : g_cfg
         wire logic wr_hit = wr_in && (addr_in == 8'(gi * 4));
         always_ff @(posedge clk_in) begin
            if (rst_in) begin
               cfg_ff[gi] <= cfg_rst(gi);
            end else if (wr_hit) begin
               cfg_ff[gi] <= wdata_in;
            end
         end
         // shadow copy so a whole set lands at one boundary
         always_ff @(posedge clk_in) begin
            if (rst_in) begin
               app_ff[gi] <= cfg_rst(gi);
            end else if (tick_wrap) begin
               app_ff[gi] <= cfg_ff[gi]; // R21
            end
         end
      end
   endgenerate

   // ------------------------------------------------------------
   // control cycle timer
   // ------------------------------------------------------------
   assign tick_wrap = (tick_cnt_ff == 12'(gsf_pkg::CTRL_CYCLES - 1));
   assign nxt_tick_cnt = tick_wrap ? 12'h000 : tick_cnt_ff + 12'h001;

   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         tick_cnt_ff <= 12'h000;
         ctrl_tick_ff <= 1'b0;
      end else begin
         tick_cnt_ff <= nxt_tick_cnt;
         ctrl_tick_ff <= tick_wrap;
      end
   end

   // ------------------------------------------------------------
   // change condition
   // ------------------------------------------------------------
   // decided from the set landing at this edge, not the one before
   wire logic [15:0] sel_code = cfg_ff[9];
   wire logic [15:0] threshold = cfg_ff[10];
   wire logic [3:0] cond_digit = digit(sel_code, gsf_pkg::SEL_COND_LSB); // R9
   wire logic [3:0] pol_digit = digit(sel_code, gsf_pkg::SEL_POL_LSB); // R9
   wire logic tune_manual = (cfg_ff[18] == gsf_pkg::TUNE_MANUAL);
   logic cond_raw;

   always_comb begin
      cond_raw = 1'b0;
      unique case (cond_digit)
         gsf_pkg::COND_HOST_CMD: cond_raw = host_switch_cmd_in; // R10 R18
         gsf_pkg::COND_CMD_FREQ: cond_raw = cmd_freq_in >= threshold; // R11
         gsf_pkg::COND_DROOP: cond_raw = droop_pulses_in >= threshold; // R11 R19
         gsf_pkg::COND_SPEED: cond_raw = motor_speed_in >= threshold; // R11 R13
         default: cond_raw = 1'b0;
      endcase
   end

   // below-threshold polarity gives gains-while-stopped vs rotating
   wire logic cond_pol = (pol_digit == gsf_pkg::POL_BELOW) ? ~cond_raw : cond_raw; // R13
   wire logic cond_valid = (cond_digit >= gsf_pkg::COND_HOST_CMD) && (cond_digit <= gsf_pkg::COND_SPEED);
   wire logic nxt_switched = tune_manual && cond_valid && cond_pol; // R4

   logic switched_ff;
   logic lag_go_ff;
   logic lpf_go_ff;

   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         switched_ff <= 1'b0;
         lag_go_ff <= 1'b0;
         lpf_go_ff <= 1'b0;
      end else begin
         lag_go_ff <= tick_wrap;
         lpf_go_ff <= lag_go_ff;
         if (tick_wrap) begin
            switched_ff <= nxt_switched; // R5
         end
      end
   end

   // ------------------------------------------------------------
   // gain selection and lag
   // ------------------------------------------------------------
   gsf_pkg::gsf_gains_t base_set;
   gsf_pkg::gsf_gains_t alt_set;
   gsf_pkg::gsf_gains_t tgt_set;
   gsf_pkg::gsf_gains_t cur_set;
   logic [15:0] cur_ff [gsf_pkg::N_GAIN];

   assign base_set = '{inertia: app_ff[1], integ: app_ff[4], speed: app_ff[3], position: app_ff[2]};
   assign alt_set = '{inertia: app_ff[5], integ: app_ff[8], speed: app_ff[7], position: app_ff[6]};
   assign tgt_set = switched_ff ? alt_set : base_set; // R5 R7

   generate
      for (gi = 0; gi < gsf_pkg::N_GAIN; gi++) begin : g_lag
         wire logic [15:0] tgt_gain = tgt_set[gi * 16 +: 16];
         // stepping one cycle after the boundary keeps all four on one edge
         always_ff @(posedge clk_in) begin
            if (rst_in) begin
               cur_ff[gi] <= 16'h0000;
            end else if (lag_go_ff) begin
               cur_ff[gi] <= lag_step(cur_ff[gi], tgt_gain, app_ff[11]); // R12
            end
         end
         assign cur_set[gi * 16 +: 16] = cur_ff[gi];
      end
   endgenerate

   // ------------------------------------------------------------
   // torque low-pass corner
   // ------------------------------------------------------------
   // inertia held in tenths, so corner = speed*10*10 / (10 + inertia)
   wire logic [23:0] lpf_num = 24'(cur_set.speed) * 24'(gsf_pkg::LPF_SCALE * gsf_pkg::INERTIA_UNIT); // R2
   wire logic [23:0] lpf_den = 24'(cur_set.inertia) + 24'(gsf_pkg::INERTIA_UNIT); // R2
   wire logic [23:0] lpf_quot = lpf_num / lpf_den;
   wire logic [15:0] lpf_auto = (lpf_quot > 24'h00ffff) ? 16'hffff : lpf_quot[15:0];
   wire logic lpf_manual = (digit(app_ff[16], gsf_pkg::LPF_MODE_LSB) == gsf_pkg::LPF_MANUAL);
   // filter is never bypassed; only the corner source changes
   wire logic [15:0] nxt_lpf = lpf_manual ? app_ff[17] : lpf_auto; // R1 R3

   // ------------------------------------------------------------
   // vibration suppression settings
   // ------------------------------------------------------------
   wire logic vib_manual = (app_ff[19] == gsf_pkg::VIB_MANUAL);
   wire logic [15:0] vib_sel = switched_ff ? app_ff[14] : app_ff[12]; // R8
   wire logic [15:0] res_sel = switched_ff ? app_ff[15] : app_ff[13]; // R8
   // outside manual mode the suppression sits at its initial values
   wire logic [15:0] nxt_vib = vib_manual ? vib_sel : gsf_pkg::RST_VIB_FREQ; // R14
   wire logic [15:0] nxt_res = vib_manual ? res_sel : gsf_pkg::RST_RES_FREQ; // R14

   // ------------------------------------------------------------
   // outputs
   // ------------------------------------------------------------
   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         ctrl_tick_out <= 1'b0;
         gain_switched_out <= 1'b0;
         model_loop_gain_out <= 16'h0000;
         position_loop_gain_out <= 16'h0000;
         speed_loop_gain_out <= 16'h0000;
         speed_integral_comp_out <= 16'h0000;
         inertia_ratio_out <= 16'h0000;
         lowpass_freq_out <= 16'h0000;
         vibration_freq_out <= 16'h0000;
         resonance_freq_out <= 16'h0000;
      end else begin
         ctrl_tick_out <= ctrl_tick_ff;
         gain_switched_out <= switched_ff;
         model_loop_gain_out <= app_ff[0]; // R6
         position_loop_gain_out <= cur_set.position;
         speed_loop_gain_out <= cur_set.speed;
         speed_integral_comp_out <= cur_set.integ;
         inertia_ratio_out <= cur_set.inertia;
         // corner waits for the stepped gains
         if (lpf_go_ff) begin
            lowpass_freq_out <= nxt_lpf;
         end
         vibration_freq_out <= nxt_vib;
         resonance_freq_out <= nxt_res;
      end
   end

   // ------------------------------------------------------------
   // register read
   // ------------------------------------------------------------
   logic [15:0] rd_mux;

   always_comb begin
      rd_mux = 16'h0000;
      if (addr_in < 8'(gsf_pkg::N_CFG * 4) && addr_in[1:0] == 2'b00) begin
         rd_mux = cfg_ff[addr_in[6:2]];
      end else begin
         unique case (addr_in)
            gsf_pkg::OFF_STATUS: rd_mux = {15'h0000, switched_ff};
            gsf_pkg::OFF_ACT_POSITION: rd_mux = cur_set.position;
            gsf_pkg::OFF_ACT_SPEED: rd_mux = cur_set.speed;
            gsf_pkg::OFF_ACT_INTEGRAL: rd_mux = cur_set.integ;
            gsf_pkg::OFF_ACT_INERTIA: rd_mux = cur_set.inertia;
            gsf_pkg::OFF_ACT_LOWPASS: rd_mux = lowpass_freq_out;
            gsf_pkg::OFF_ACT_VIBRATION: rd_mux = vibration_freq_out;
            gsf_pkg::OFF_ACT_RESONANCE: rd_mux = resonance_freq_out;
            default: rd_mux = 16'h0000;
         endcase
      end
   end

   // data holds only in the cycle after the strobe
   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         rdata_out <= 16'h0000;
      end else begin
         rdata_out <= rd_in ? rd_mux : 16'h0000;
      end
   end

endmodule // gsf_core

/* File: include/gsf_pkg.sv */
package gsf_pkg;
   // ------------------------------------------------------------
   // bus and data widths
   // ------------------------------------------------------------
   localparam int DW = 16;
   localparam int AW = 8;
   localparam int N_CFG = 20;
   localparam int N_GAIN = 4;

   // ------------------------------------------------------------
   // writable parameter offsets (byte addresses)
   // ------------------------------------------------------------
   localparam logic [7:0] OFF_MODEL_LOOP_GAIN = 8'h00;
   localparam logic [7:0] OFF_INERTIA_RATIO = 8'h04;
   localparam logic [7:0] OFF_POSITION_LOOP_GAIN = 8'h08;
   localparam logic [7:0] OFF_SPEED_LOOP_GAIN = 8'h0c;
   localparam logic [7:0] OFF_SPEED_INTEGRAL_COMP = 8'h10;
   localparam logic [7:0] OFF_ALT_INERTIA_RATIO = 8'h14;
   localparam logic [7:0] OFF_ALT_POSITION_LOOP_GAIN = 8'h18;
   localparam logic [7:0] OFF_ALT_SPEED_LOOP_GAIN = 8'h1c;
   localparam logic [7:0] OFF_ALT_SPEED_INTEGRAL_COMP = 8'h20;
   localparam logic [7:0] OFF_GAIN_SWITCH_SELECT = 8'h24;
   localparam logic [7:0] OFF_GAIN_SWITCH_THRESHOLD = 8'h28;
   localparam logic [7:0] OFF_GAIN_SWITCH_TIME_CONSTANT = 8'h2c;
   localparam logic [7:0] OFF_VIBRATION_FREQ_SETTING = 8'h30;
   localparam logic [7:0] OFF_RESONANCE_FREQ_SETTING = 8'h34;
   localparam logic [7:0] OFF_ALT_VIBRATION_FREQ = 8'h38;
   localparam logic [7:0] OFF_ALT_RESONANCE_FREQ = 8'h3c;
   localparam logic [7:0] OFF_LOWPASS_SELECT = 8'h40;
   localparam logic [7:0] OFF_LOWPASS_MANUAL_FREQ = 8'h44;
   localparam logic [7:0] OFF_TUNING_MODE_SELECT = 8'h48;
   localparam logic [7:0] OFF_VIB_SUPPRESS_MODE = 8'h4c;

   // ------------------------------------------------------------
   // read-only status offsets
   // ------------------------------------------------------------
   localparam logic [7:0] OFF_STATUS = 8'h50;
   localparam logic [7:0] OFF_ACT_POSITION = 8'h54;
   localparam logic [7:0] OFF_ACT_SPEED = 8'h58;
   localparam logic [7:0] OFF_ACT_INTEGRAL = 8'h5c;
   localparam logic [7:0] OFF_ACT_INERTIA = 8'h60;
   localparam logic [7:0] OFF_ACT_LOWPASS = 8'h64;
   localparam logic [7:0] OFF_ACT_VIBRATION = 8'h68;
   localparam logic [7:0] OFF_ACT_RESONANCE = 8'h6c;

   // ------------------------------------------------------------
   // reset values (inertia in 0.1 units, frequencies in 0.1 hz)
   // ------------------------------------------------------------
   localparam logic [15:0] RST_MODEL_LOOP_GAIN = 16'h0064;
   localparam logic [15:0] RST_INERTIA_RATIO = 16'h0028;
   localparam logic [15:0] RST_POSITION_LOOP_GAIN = 16'h0078;
   localparam logic [15:0] RST_SPEED_LOOP_GAIN = 16'h0bb8;
   localparam logic [15:0] RST_SPEED_INTEGRAL_COMP = 16'h0014;
   localparam logic [15:0] RST_ALT_INERTIA_RATIO = 16'h0064;
   localparam logic [15:0] RST_ALT_POSITION_LOOP_GAIN = 16'h0054;
   localparam logic [15:0] RST_ALT_SPEED_LOOP_GAIN = 16'h0fa0;
   localparam logic [15:0] RST_ALT_SPEED_INTEGRAL_COMP = 16'h0032;
   localparam logic [15:0] RST_GAIN_SWITCH_SELECT = 16'h0001;
   localparam logic [15:0] RST_GAIN_SWITCH_THRESHOLD = 16'h0032;
   localparam logic [15:0] RST_GAIN_SWITCH_TIME_CONSTANT = 16'h0064;
   localparam logic [15:0] RST_VIB_FREQ = 16'h0064;
   localparam logic [15:0] RST_RES_FREQ = 16'h0064;
   localparam logic [15:0] RST_LOWPASS_SELECT = 16'h0000;
   localparam logic [15:0] RST_LOWPASS_MANUAL_FREQ = 16'h0c44;
   localparam logic [15:0] RST_TUNING_MODE_SELECT = 16'h0001;
   localparam logic [15:0] RST_VIB_SUPPRESS_MODE = 16'h0000;

   // ------------------------------------------------------------
   // field positions and codes
   // ------------------------------------------------------------
   localparam int DIGIT_W = 4;
   localparam int SEL_COND_LSB = 0;
   localparam int SEL_POL_LSB = 4;
   localparam int LPF_MODE_LSB = 4;
   localparam logic [3:0] COND_HOST_CMD = 4'h1;
   localparam logic [3:0] COND_CMD_FREQ = 4'h2;
   localparam logic [3:0] COND_DROOP = 4'h3;
   localparam logic [3:0] COND_SPEED = 4'h4;
   localparam logic [3:0] POL_BELOW = 4'h1;
   localparam logic [3:0] LPF_MANUAL = 4'h1;
   localparam logic [15:0] TUNE_MANUAL = 16'h0003;
   localparam logic [15:0] VIB_MANUAL = 16'h0002;

   // ------------------------------------------------------------
   // timing
   // ------------------------------------------------------------
   localparam int CLK_PERIOD_NS = 20;
   localparam int CTRL_PERIOD_NS = 50000;
   localparam int CTRL_CYCLES = CTRL_PERIOD_NS / CLK_PERIOD_NS;
   localparam int MS_NS = 1000000;
   localparam int TICKS_PER_MS = MS_NS / CTRL_PERIOD_NS;
   localparam int LPF_SCALE = 10;
   localparam int INERTIA_UNIT = 10;

   typedef struct packed {
      logic [15:0] inertia;
      logic [15:0] integ;
      logic [15:0] speed;
      logic [15:0] position;
   } gsf_gains_t;
endpackage

/* File: tb/gsf_core_properties.sv */
module gsf_checker (
   input wire logic clk_in,
   input wire logic rst_in,
   input wire logic ctrl_tick_out,
   input wire logic gain_switched_out,
   input wire logic [15:0] model_loop_gain_out,
   input wire logic [15:0] position_loop_gain_out,
   input wire logic [15:0] speed_loop_gain_out,
   input wire logic [15:0] inertia_ratio_out,
   input wire logic [15:0] lowpass_freq_out,
   input wire logic [15:0] vibration_freq_out
);
   timeunit 1ns;
   timeprecision 1ps;
   // ------------------------------------------------------------
   // boundary tracking
   // ------------------------------------------------------------
   logic started_ff;
   logic [11:0] gap_ff;
   wire logic [11:0] nxt_gap = ctrl_tick_out ? 12'h000 : gap_ff + 12'h001;
   always_ff @(posedge clk_in) begin
      started_ff <= !rst_in && (started_ff || ctrl_tick_out);
      gap_ff <= rst_in ? 12'h000 : nxt_gap;
   end
   default clocking cb @(posedge clk_in); endclocking
   default disable iff (rst_in);
   // ------------------------------------------------------------
   // properties
   // ------------------------------------------------------------
   a_tick_spacing: assert property (ctrl_tick_out && started_ff |-> gap_ff == 12'(gsf_pkg::CTRL_CYCLES - 1))
      else $error("tick spacing wrong");
   a_switch_at_tick: assert property ($changed(gain_switched_out) |-> ctrl_tick_out)
      else $error("switch off boundary");
   a_gains_at_tick: assert property (($changed(position_loop_gain_out) || $changed(speed_loop_gain_out)
      || $changed(inertia_ratio_out)) |-> $past(ctrl_tick_out))
      else $error("gains off boundary");
   a_model_unswitched: assert property ($changed(gain_switched_out) |-> $stable(model_loop_gain_out))
      else $error("model gain switched");
   a_switch_moves_gains: assert property ($changed(gain_switched_out)
      |=> $changed(speed_loop_gain_out) && $changed(position_loop_gain_out))
      else $error("gains did not follow switch");
   a_lowpass_follows: assert property ($changed(lowpass_freq_out) |-> $past(ctrl_tick_out))
      else $error("lowpass off boundary");
   a_lowpass_always_on: assert property (started_ff |-> lowpass_freq_out != 16'h0000)
      else $error("lowpass is zero");
   a_vib_at_tick: assert property (started_ff && $changed(vibration_freq_out) |-> ctrl_tick_out)
      else $error("vibration off boundary");
   c_switch_on: cover property ($rose(gain_switched_out));
   c_switch_off: cover property ($fell(gain_switched_out));
   c_tick: cover property (ctrl_tick_out && started_ff);
endmodule // gsf_checker

bind gsf_core gsf_checker gsf_checker_inst (
   .clk_in, .rst_in, .ctrl_tick_out, .gain_switched_out, .model_loop_gain_out, .position_loop_gain_out,
   .speed_loop_gain_out, .inertia_ratio_out, .lowpass_freq_out, .vibration_freq_out
);

/* File: tb/gsf_host_model.sv */
module gsf_host_model (
   input wire logic clk_in,
   input wire logic [15:0] rdata_in,
   output logic [7:0] addr_out,
   output logic [15:0] wdata_out,
   output logic wr_out,
   output logic rd_out,
   output logic switch_cmd_out
);
   timeunit 1ns;
   timeprecision 1ps;
   initial {addr_out, wdata_out, wr_out, rd_out, switch_cmd_out} = 27'h0000000;
   task automatic write_reg(input logic [7:0] a, input logic [15:0] d);
      @(posedge clk_in);
      addr_out <= a;
      wdata_out <= d;
      wr_out <= 1'b1;
      @(posedge clk_in);
      wr_out <= 1'b0;
      // scrambled: a stale word never looks fresh
      wdata_out <= ~d;
   endtask
   task automatic read_reg(input logic [7:0] a, output logic [15:0] d);
      @(posedge clk_in);
      addr_out <= a;
      rd_out <= 1'b1;
      @(posedge clk_in);
      rd_out <= 1'b0;
      @(posedge clk_in);
      d = rdata_in;
   endtask
   task automatic set_switch(input logic v);
      @(posedge clk_in);
      switch_cmd_out <= v;
   endtask
   task automatic load_profile();
      // load really changes here
      write_reg(gsf_pkg::OFF_ALT_INERTIA_RATIO, 16'h0064);
      // 30.0 hz stays above 1.5 x model gain / 2 pi
      write_reg(gsf_pkg::OFF_VIBRATION_FREQ_SETTING, 16'h012c);
      write_reg(gsf_pkg::OFF_RESONANCE_FREQ_SETTING, 16'h015e);
      write_reg(gsf_pkg::OFF_ALT_VIBRATION_FREQ, 16'h0190);
      write_reg(gsf_pkg::OFF_ALT_RESONANCE_FREQ, 16'h01c2);
      write_reg(gsf_pkg::OFF_VIB_SUPPRESS_MODE, gsf_pkg::VIB_MANUAL);
   endtask
endmodule // gsf_host_model

/* File: tb/test_gsf_core.sv */
module test_gsf_core;
   timeunit 1ns;
   timeprecision 1ps;
   // ------------------------------------------------------------
   // signals and instances
   // ------------------------------------------------------------
   logic clk_in = 1'b0;
   logic rst_in = 1'b1;
   logic [7:0] addr;
   logic [15:0] wdata, rdata, model_g, pos_g, speed_g, integ_g, inertia_g, lpf, vib, res;
   logic wr, rd, host_cmd, tick, switched;
   logic [15:0] cmd_freq = 16'h0000, droop = 16'h0000, speed = 16'h0000;
   int errors = 0;
   int total_checks = 0;
   always #10 clk_in = ~clk_in;
   gsf_host_model gsf_host_model_inst (.clk_in(clk_in), .rdata_in(rdata), .addr_out(addr),
      .wdata_out(wdata), .wr_out(wr), .rd_out(rd), .switch_cmd_out(host_cmd));
   gsf_core gsf_core_inst (.clk_in(clk_in), .rst_in(rst_in), .addr_in(addr), .wdata_in(wdata),
      .wr_in(wr), .rd_in(rd), .rdata_out(rdata), .host_switch_cmd_in(host_cmd),
      .cmd_freq_in(cmd_freq), .droop_pulses_in(droop), .motor_speed_in(speed),
      .ctrl_tick_out(tick), .gain_switched_out(switched), .model_loop_gain_out(model_g),
      .position_loop_gain_out(pos_g), .speed_loop_gain_out(speed_g),
      .speed_integral_comp_out(integ_g), .inertia_ratio_out(inertia_g),
      .lowpass_freq_out(lpf), .vibration_freq_out(vib), .resonance_freq_out(res));
   // ------------------------------------------------------------
   // helpers
   // ------------------------------------------------------------
   task automatic report_and_stop();
      $display("comparisons %0d mismatches %0d", total_checks, errors);
      if (errors == 0 && total_checks > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask
   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      total_checks++;
      if (seen !== exp) begin
         errors++;
         $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic wr_reg(input logic [7:0] a, input logic [15:0] d);
      gsf_host_model_inst.write_reg(a, d);
   endtask
   task automatic rd_reg(input logic [7:0] a, output logic [15:0] d);
      gsf_host_model_inst.read_reg(a, d);
   endtask
   // returns once the corner of the new boundary has landed
   task automatic wait_tick();
      int n = 0;
      @(posedge clk_in);
      while (tick !== 1'b1 && n < 3000) begin
         @(posedge clk_in);
         n++;
      end
      if (n >= 3000) begin
         errors++;
         report_and_stop();
      end
      #1;
   endtask
   task automatic drive(input int i, input logic [15:0] v);
      @(posedge clk_in);
      cmd_freq <= (i == 0 || i == 3) ? v : 16'h0000;
      droop <= (i == 1 || i == 3) ? v : 16'h0000;
      speed <= (i == 2 || i == 3) ? v : 16'h0000;
   endtask
   // ------------------------------------------------------------
   // scenarios
   // ------------------------------------------------------------
   task automatic t_bus();
      logic [15:0] v;
      rd_reg(gsf_pkg::OFF_GAIN_SWITCH_SELECT, v);
      check(v, gsf_pkg::RST_GAIN_SWITCH_SELECT);
      rd_reg(gsf_pkg::OFF_TUNING_MODE_SELECT, v);
      check(v, gsf_pkg::RST_TUNING_MODE_SELECT);
      wr_reg(gsf_pkg::OFF_STATUS, 16'hffff);
      rd_reg(gsf_pkg::OFF_STATUS, v);
      check(v, 16'h0000);
      rd_reg(8'h70, v);
      check(v, 16'h0000);
      $display("bus test done");
   endtask
   task automatic t_defaults();
      wait_tick();
      check(model_g, gsf_pkg::RST_MODEL_LOOP_GAIN);
      check(pos_g, gsf_pkg::RST_POSITION_LOOP_GAIN);
      check(speed_g, gsf_pkg::RST_SPEED_LOOP_GAIN);
      check(integ_g, gsf_pkg::RST_SPEED_INTEGRAL_COMP);
      check(inertia_g, gsf_pkg::RST_INERTIA_RATIO);
      check(lpf, 16'd6000);
      $display("defaults test done");
   endtask
   task automatic t_tuning_gate();
      gsf_host_model_inst.set_switch(1'b1);
      wait_tick();
      check(16'(switched), 16'h0000);
      check(pos_g, gsf_pkg::RST_POSITION_LOOP_GAIN);
      $display("tuning gate test done");
   endtask
   task automatic t_host_switch();
      wr_reg(gsf_pkg::OFF_TUNING_MODE_SELECT, gsf_pkg::TUNE_MANUAL);
      gsf_host_model_inst.load_profile();
      wait_tick();
      check(16'(switched), 16'h0001);
      check(pos_g, 16'd84);
      check(speed_g, 16'd4000);
      check(integ_g, 16'd50);
      check(inertia_g, 16'd100);
      check(model_g, gsf_pkg::RST_MODEL_LOOP_GAIN);
      check(vib, 16'h0190);
      check(res, 16'h01c2);
      check(lpf, 16'd3636);
      gsf_host_model_inst.set_switch(1'b0);
      wait_tick();
      check(16'(switched), 16'h0000);
      check(pos_g, 16'd120);
      check(vib, 16'h012c);
      check(res, 16'h015e);
      $display("host switch test done");
   endtask
   task automatic t_thresholds();
      for (int i = 0; i < 3; i++) begin
         wr_reg(gsf_pkg::OFF_GAIN_SWITCH_SELECT, 16'(i + 2));
         for (int k = 0; k < 2; k++) begin
            drive(i, k ? 16'h0031 : 16'h0033);
            wait_tick();
            check(16'(switched), 16'(k == 0));
         end
      end
      // second digit 1: switch below threshold
      wr_reg(gsf_pkg::OFF_GAIN_SWITCH_SELECT, 16'h0013);
      wait_tick();
      check(16'(switched), 16'h0001);
      wr_reg(gsf_pkg::OFF_GAIN_SWITCH_SELECT, 16'h0000);
      drive(3, 16'h0033);
      wait_tick();
      check(16'(switched), 16'h0000);
      check(pos_g, 16'd120);
      $display("threshold test done");
   endtask
   task automatic t_lowpass_manual();
      wr_reg(gsf_pkg::OFF_LOWPASS_MANUAL_FREQ, 16'h0200);
      wr_reg(gsf_pkg::OFF_LOWPASS_SELECT, 16'h0010);
      wait_tick();
      check(lpf, 16'h0200);
      $display("manual lowpass test done");
   endtask
   task automatic t_lag();
      wr_reg(gsf_pkg::OFF_LOWPASS_SELECT, 16'h0000);
      wr_reg(gsf_pkg::OFF_GAIN_SWITCH_TIME_CONSTANT, 16'h0001);
      wr_reg(gsf_pkg::OFF_GAIN_SWITCH_SELECT, 16'h0001);
      gsf_host_model_inst.set_switch(1'b1);
      wait_tick();
      // 1 ms lag: a twentieth of the gap per step, min one lsb
      check(speed_g, 16'd3050);
      check(pos_g, 16'd119);
      check(integ_g, 16'd21);
      check(inertia_g, 16'd43);
      check(lpf, 16'd5754);
      $display("lag test done");
   endtask
   // ------------------------------------------------------------
   // main sequence
   // ------------------------------------------------------------
   initial begin
      repeat (6) @(posedge clk_in);
      rst_in <= 1'b0;
      wr_reg(gsf_pkg::OFF_GAIN_SWITCH_TIME_CONSTANT, 16'h0000);
      t_bus();
      t_defaults();
      t_tuning_gate();
      t_host_switch();
      t_thresholds();
      t_lowpass_manual();
      t_lag();
      report_and_stop();
   end
endmodule // test_gsf_core
